/* design/halfword_load_pkg.sv */
// Constants, types and helpers shared by the halfword load decode and execute block.
// What this block does
// - Primary code 31 with extended code 790 is the byte-reversed indexed load, with target, base and index fields at 6-10, 11-15 and 16-20.
// - The byte-reversed load puts halfword bits 00-07 in target bits 24-31, bits 08-15 in target bits 16-23, and zeros in bits 00-15.
// - Indexed forms address base plus index when the base field is nonzero, and the index alone when it is zero.
// - Displacement forms sign-extend the 16-bit displacement to 32 bits and add the base only when the base field is nonzero.
// - Primary code 40 is the zero-extending displacement load, with target 6-10, base 11-15 and displacement 16-31.
// - Every zero-extending load puts the halfword in target bits 16-31 and zeros in bits 0-15.
// - Primary code 41 is the zero-extending displacement load with base update, using the same field positions.
// - Update forms write the address back to the base only when base differs from target, base is nonzero and no fault was raised.
// - Primary code 31 with extended code 331 is the zero-extending indexed load with base update.
// - Primary code 31 with extended code 279 is the zero-extending indexed load without update.
// - The exception register and condition field 0 are never touched by these loads.
// - The indexed load without update writes only the zero-extended target and never the base register.
package halfword_load_pkg;

  localparam int WORD_WIDTH = 32;
  localparam int HALF_WIDTH = 16;
  localparam int BYTE_WIDTH = 8;
  localparam int REG_INDEX_WIDTH = 5;

  // Instruction bit 0 is the most significant bit of the word.
  localparam int PRIMARY_MSB = 31;
  localparam int PRIMARY_LSB = 26;
  localparam int TARGET_MSB = 25;
  localparam int TARGET_LSB = 21;
  localparam int BASE_MSB = 20;
  localparam int BASE_LSB = 16;
  localparam int INDEX_MSB = 15;
  localparam int INDEX_LSB = 11;
  localparam int EXTENDED_MSB = 10;
  localparam int EXTENDED_LSB = 1;
  localparam int DISP_MSB = 15;
  localparam int DISP_LSB = 0;

  localparam logic [5:0] PRIMARY_EXTENDED = 6'h1f;
  localparam logic [5:0] PRIMARY_ZERO_DISP = 6'h28;
  localparam logic [5:0] PRIMARY_ZERO_DISP_UPDATE = 6'h29;
  localparam logic [9:0] EXT_BYTE_REVERSE = 10'h316;
  localparam logic [9:0] EXT_ZERO_INDEXED_UPDATE = 10'h14b;
  localparam logic [9:0] EXT_ZERO_INDEXED = 10'h117;

  localparam logic [REG_INDEX_WIDTH-1:0] REG_ZERO = 5'h00;
  localparam logic [HALF_WIDTH-1:0] UPPER_CLEAR = 16'h0000;
  localparam logic [WORD_WIDTH-1:0] WORD_RESET = 32'h0000_0000;

  typedef enum logic [2:0] {
    OP_NONE = 3'h0,
    OP_BYTE_REVERSE = 3'h1,
    OP_ZERO_DISP = 3'h2,
    OP_ZERO_DISP_UPDATE = 3'h3,
    OP_ZERO_INDEXED_UPDATE = 3'h4,
    OP_ZERO_INDEXED = 3'h5
  } load_op_type;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ISSUE = 2'b01,
    ST_AWAIT = 2'b11,
    ST_RETIRE = 2'b10
  } load_state_type;

  function automatic logic [WORD_WIDTH-1:0] sign_extend_disp(input logic [HALF_WIDTH-1:0] disp);
    return {{HALF_WIDTH{disp[HALF_WIDTH-1]}}, disp};
  endfunction : sign_extend_disp

  function automatic logic is_update(input load_op_type op);
    return (op == OP_ZERO_DISP_UPDATE) || (op == OP_ZERO_INDEXED_UPDATE);
  endfunction : is_update

  function automatic logic uses_displacement(input load_op_type op);
    return (op == OP_ZERO_DISP) || (op == OP_ZERO_DISP_UPDATE);
  endfunction : uses_displacement

endpackage : halfword_load_pkg

/* design/halfword_load_field_decoder.sv */
// Combinational decoder that splits an instruction word into load kind and operand fields.
`timescale 1ns/1ps
module halfword_load_field_decoder (
  input wire logic [31:0] instr_word,
  output halfword_load_pkg::load_op_type decoded_op,
  output logic [4:0] target_field,
  output logic [4:0] base_field,
  output logic [4:0] index_field,
  output logic [15:0] displacement
);
  logic [5:0] primary;
  logic [9:0] extended;

  assign primary = instr_word[halfword_load_pkg::PRIMARY_MSB:halfword_load_pkg::PRIMARY_LSB];
  assign extended = instr_word[halfword_load_pkg::EXTENDED_MSB:halfword_load_pkg::EXTENDED_LSB];
  assign target_field = instr_word[halfword_load_pkg::TARGET_MSB:halfword_load_pkg::TARGET_LSB];
  assign base_field = instr_word[halfword_load_pkg::BASE_MSB:halfword_load_pkg::BASE_LSB];
  assign index_field = instr_word[halfword_load_pkg::INDEX_MSB:halfword_load_pkg::INDEX_LSB];
  assign displacement = instr_word[halfword_load_pkg::DISP_MSB:halfword_load_pkg::DISP_LSB];

  // The lowest instruction bit is ignored by every indexed form.
  always_comb begin
    decoded_op = halfword_load_pkg::OP_NONE;
    if (primary == halfword_load_pkg::PRIMARY_ZERO_DISP) begin
      decoded_op = halfword_load_pkg::OP_ZERO_DISP;
    end else if (primary == halfword_load_pkg::PRIMARY_ZERO_DISP_UPDATE) begin
      decoded_op = halfword_load_pkg::OP_ZERO_DISP_UPDATE;
    end else if (primary == halfword_load_pkg::PRIMARY_EXTENDED) begin
      if (extended == halfword_load_pkg::EXT_BYTE_REVERSE) begin
        decoded_op = halfword_load_pkg::OP_BYTE_REVERSE;
      end else if (extended == halfword_load_pkg::EXT_ZERO_INDEXED_UPDATE) begin
        decoded_op = halfword_load_pkg::OP_ZERO_INDEXED_UPDATE;
      end else if (extended == halfword_load_pkg::EXT_ZERO_INDEXED) begin
        decoded_op = halfword_load_pkg::OP_ZERO_INDEXED;
      end
    end
  end
endmodule : halfword_load_field_decoder

/* design/halfword_load_address_gen.sv */
// Effective address adder for displacement and indexed halfword loads.
`timescale 1ns/1ps
module halfword_load_address_gen (
  input wire logic [31:0] base_data,
  input wire logic [31:0] index_data,
  input wire logic [15:0] displacement,
  input wire logic base_is_zero,
  input wire logic use_displacement,
  output logic [31:0] effective_address
);
  logic [31:0] offset;
  logic [31:0] base_term;

  // A zero base field selects the constant zero, not register zero.
  assign offset = use_displacement ? halfword_load_pkg::sign_extend_disp(displacement)
                                   : index_data;
  assign base_term = base_is_zero ? halfword_load_pkg::WORD_RESET : base_data;
  assign effective_address = base_term + offset;
endmodule : halfword_load_address_gen

/* design/halfword_load_decode_execute.sv */
// Decode and execute of the zero-extending and byte-reversed halfword loads.
`timescale 1ns/1ps
module halfword_load_decode_execute (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic instr_valid,
  input wire logic [31:0] instr_word,
  output logic instr_ready,
  output logic [4:0] base_read_index,
  input wire logic [31:0] base_read_data,
  output logic [4:0] index_read_index,
  input wire logic [31:0] index_read_data,
  output logic mem_request,
  output logic [31:0] mem_address,
  input wire logic mem_accept,
  input wire logic mem_response_valid,
  input wire logic [15:0] mem_read_data,
  input wire logic mem_alignment_fault,
  input wire logic mem_storage_fault,
  output logic target_write_enable,
  output logic [4:0] target_write_index,
  output logic [31:0] target_write_data,
  output logic base_write_enable,
  output logic [4:0] base_write_index,
  output logic [31:0] base_write_data,
  output logic illegal_instruction,
  output logic load_fault
);
  halfword_load_pkg::load_state_type state;
  halfword_load_pkg::load_state_type next_state;
  halfword_load_pkg::load_op_type op;
  halfword_load_pkg::load_op_type next_op;
  halfword_load_pkg::load_op_type decoded_op;
  logic [4:0] target;
  logic [4:0] next_target;
  logic [4:0] base;
  logic [4:0] next_base;
  logic [31:0] address;
  logic [31:0] next_address;
  logic [4:0] decoded_target;
  logic [4:0] decoded_base;
  logic [4:0] decoded_index;
  logic [15:0] decoded_disp;
  logic [31:0] effective_address;
  logic fault;
  logic respond;
  logic next_target_write_enable;
  logic [4:0] next_target_write_index;
  logic [31:0] next_target_write_data;
  logic next_base_write_enable;
  logic [4:0] next_base_write_index;
  logic [31:0] next_base_write_data;
  logic next_illegal_instruction;
  logic next_load_fault;

  halfword_load_field_decoder field_decoder (
    .instr_word(instr_word),
    .decoded_op(decoded_op),
    .target_field(decoded_target),
    .base_field(decoded_base),
    .index_field(decoded_index),
    .displacement(decoded_disp)
  );

  halfword_load_address_gen address_gen (
    .base_data(base_read_data),
    .index_data(index_read_data),
    .displacement(decoded_disp),
    .base_is_zero(decoded_base == halfword_load_pkg::REG_ZERO),
    .use_displacement(halfword_load_pkg::uses_displacement(decoded_op)),
    .effective_address(effective_address)
  );

  // Operand reads follow the word on offer so the address is formed in the accept cycle.
  assign base_read_index = decoded_base;
  assign index_read_index = decoded_index;
  assign instr_ready = (state == halfword_load_pkg::ST_IDLE);
  assign mem_request = (state == halfword_load_pkg::ST_ISSUE);
  assign mem_address = address;
  assign fault = mem_alignment_fault | mem_storage_fault;
  assign respond = (state == halfword_load_pkg::ST_AWAIT) && mem_response_valid;

  always_comb begin
    next_state = state;
    next_op = op;
    next_target = target;
    next_base = base;
    next_address = address;
    unique case (state)
      halfword_load_pkg::ST_IDLE: begin
        if (instr_valid && (decoded_op != halfword_load_pkg::OP_NONE)) begin
          next_state = halfword_load_pkg::ST_ISSUE;
          next_op = decoded_op;
          next_target = decoded_target;
          next_base = decoded_base;
          next_address = effective_address;
        end
      end
      halfword_load_pkg::ST_ISSUE: begin
        if (mem_accept) begin
          next_state = halfword_load_pkg::ST_AWAIT;
        end
      end
      halfword_load_pkg::ST_AWAIT: begin
        if (mem_response_valid) begin
          next_state = halfword_load_pkg::ST_RETIRE;
        end
      end
      halfword_load_pkg::ST_RETIRE: begin
        next_state = halfword_load_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      state <= halfword_load_pkg::ST_IDLE;
      op <= halfword_load_pkg::OP_NONE;
      target <= halfword_load_pkg::REG_ZERO;
      base <= halfword_load_pkg::REG_ZERO;
      address <= halfword_load_pkg::WORD_RESET;
    end else begin
      state <= next_state;
      op <= next_op;
      target <= next_target;
      base <= next_base;
      address <= next_address;
    end
  end

  // Only target and base write ports exist, so the exception register and
  // condition field 0 cannot change.
  always_comb begin
    next_target_write_enable = respond && !fault;
    next_target_write_index = target;
    next_target_write_data = target_write_data;
    if (respond) begin
      if (op == halfword_load_pkg::OP_BYTE_REVERSE) begin
        next_target_write_data = {halfword_load_pkg::UPPER_CLEAR,
          mem_read_data[halfword_load_pkg::BYTE_WIDTH-1:0],
          mem_read_data[halfword_load_pkg::HALF_WIDTH-1:halfword_load_pkg::BYTE_WIDTH]};
      end else begin
        next_target_write_data = {halfword_load_pkg::UPPER_CLEAR, mem_read_data};
      end
    end
    // A base equal to the target would race two writes to one register; the load wins.
    next_base_write_enable = respond && !fault && halfword_load_pkg::is_update(op)
      && (base != halfword_load_pkg::REG_ZERO) && (base != target);
    next_base_write_index = base;
    next_base_write_data = address;
    next_illegal_instruction = instr_ready && instr_valid
      && (decoded_op == halfword_load_pkg::OP_NONE);
    next_load_fault = respond && fault;
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      target_write_enable <= 1'b0;
      target_write_index <= halfword_load_pkg::REG_ZERO;
      target_write_data <= halfword_load_pkg::WORD_RESET;
      base_write_enable <= 1'b0;
      base_write_index <= halfword_load_pkg::REG_ZERO;
      base_write_data <= halfword_load_pkg::WORD_RESET;
      illegal_instruction <= 1'b0;
      load_fault <= 1'b0;
    end else begin
      target_write_enable <= next_target_write_enable;
      target_write_index <= next_target_write_index;
      target_write_data <= next_target_write_data;
      base_write_enable <= next_base_write_enable;
      base_write_index <= next_base_write_index;
      base_write_data <= next_base_write_data;
      illegal_instruction <= next_illegal_instruction;
      load_fault <= next_load_fault;
    end
  end

  // Checks on the decode and retire behaviour.
  logic [5:0] chk_primary;
  logic [9:0] chk_extended;
  logic chk_take;
  assign chk_primary = instr_word[halfword_load_pkg::PRIMARY_MSB:halfword_load_pkg::PRIMARY_LSB];
  assign chk_extended =
    instr_word[halfword_load_pkg::EXTENDED_MSB:halfword_load_pkg::EXTENDED_LSB];
  assign chk_take = instr_ready && instr_valid;

  default clocking chk_cb @(posedge sys_clk);
  endclocking
  default disable iff (!reset_n);

  AST_DECODE_BYTE_REVERSE: assert property (
    chk_take && chk_primary == halfword_load_pkg::PRIMARY_EXTENDED
      && chk_extended == halfword_load_pkg::EXT_BYTE_REVERSE
    |=> state == halfword_load_pkg::ST_ISSUE && op == halfword_load_pkg::OP_BYTE_REVERSE
      && target == $past(instr_word[halfword_load_pkg::TARGET_MSB:halfword_load_pkg::TARGET_LSB])
      && base == $past(instr_word[halfword_load_pkg::BASE_MSB:halfword_load_pkg::BASE_LSB]))
    else $error("Byte-reversed load was not decoded.");

  AST_DECODE_DISP: assert property (
    chk_take && chk_primary == halfword_load_pkg::PRIMARY_ZERO_DISP
    |=> op == halfword_load_pkg::OP_ZERO_DISP && mem_request)
    else $error("Displacement load was not decoded.");

  AST_DECODE_DISP_UPDATE: assert property (
    chk_take && chk_primary == halfword_load_pkg::PRIMARY_ZERO_DISP_UPDATE
    |=> op == halfword_load_pkg::OP_ZERO_DISP_UPDATE && mem_request)
    else $error("Displacement update load was not decoded.");

  AST_DECODE_INDEXED_UPDATE: assert property (
    chk_take && chk_primary == halfword_load_pkg::PRIMARY_EXTENDED
      && chk_extended == halfword_load_pkg::EXT_ZERO_INDEXED_UPDATE
    |=> op == halfword_load_pkg::OP_ZERO_INDEXED_UPDATE && mem_request)
    else $error("Indexed update load was not decoded.");

  AST_DECODE_INDEXED: assert property (
    chk_take && chk_primary == halfword_load_pkg::PRIMARY_EXTENDED
      && chk_extended == halfword_load_pkg::EXT_ZERO_INDEXED
    |=> op == halfword_load_pkg::OP_ZERO_INDEXED && mem_request)
    else $error("Indexed load was not decoded.");

  AST_ADDRESS_INDEXED: assert property (
    chk_take && chk_primary == halfword_load_pkg::PRIMARY_EXTENDED
      && decoded_op != halfword_load_pkg::OP_NONE
    |=> mem_address == (($past(decoded_base) == halfword_load_pkg::REG_ZERO)
      ? $past(index_read_data) : $past(base_read_data) + $past(index_read_data)))
    else $error("Indexed effective address is wrong.");

  AST_ADDRESS_DISP: assert property (
    chk_take && halfword_load_pkg::uses_displacement(decoded_op)
    |=> mem_address == halfword_load_pkg::sign_extend_disp($past(decoded_disp))
      + (($past(decoded_base) == halfword_load_pkg::REG_ZERO) ? halfword_load_pkg::WORD_RESET
      : $past(base_read_data)))
    else $error("Displacement effective address is wrong.");

  AST_BYTE_REVERSE_DATA: assert property (
    respond && !fault && op == halfword_load_pkg::OP_BYTE_REVERSE
    |=> target_write_enable && target_write_data == {halfword_load_pkg::UPPER_CLEAR,
      $past(mem_read_data[7:0]), $past(mem_read_data[15:8])})
    else $error("Byte-reversed result is wrong.");

  AST_ZERO_EXTEND_DATA: assert property (
    respond && !fault && op != halfword_load_pkg::OP_BYTE_REVERSE
    |=> target_write_enable && target_write_data[31:16] == halfword_load_pkg::UPPER_CLEAR
      && target_write_data[15:0] == $past(mem_read_data))
    else $error("Zero-extended result is wrong.");

  AST_UPDATE_GUARD: assert property (
    base_write_enable |-> target_write_enable && base_write_index != halfword_load_pkg::REG_ZERO
      && base_write_index != target_write_index && base_write_data == mem_address
      && halfword_load_pkg::is_update(op))
    else $error("Base update written without its conditions.");

  AST_UPDATE_TAKEN: assert property (
    respond && !fault && halfword_load_pkg::is_update(op)
      && base != halfword_load_pkg::REG_ZERO && base != target
    |=> base_write_enable ##1 !base_write_enable)
    else $error("Base update was missed.");

  AST_FAULT_NO_WRITE: assert property (
    respond && fault |=> !target_write_enable && !base_write_enable && load_fault)
    else $error("Faulting load modified a register.");

  AST_SINGLE_RETIRE: assert property (
    target_write_enable |-> state == halfword_load_pkg::ST_RETIRE ##1 !target_write_enable)
    else $error("Target written outside retire.");

  // The base port is written only for an update form with a usable base register.
  AST_NO_BASE_PLAIN: assert property (
    respond && !halfword_load_pkg::is_update(op) |=> !base_write_enable)
    else $error("Base written by a plain load.");

  AST_ZERO_BASE_KEPT: assert property (
    respond && base == halfword_load_pkg::REG_ZERO |=> !base_write_enable)
    else $error("Register zero was updated.");

  AST_SAME_BASE_KEPT: assert property (
    respond && base == target |=> !base_write_enable)
    else $error("Base update hit the target.");

  AST_TARGET_INDEX: assert property (
    respond && !fault |=> target_write_index == $past(target))
    else $error("Result went to the wrong register.");

  AST_ILLEGAL_WORD: assert property (
    chk_take && decoded_op == halfword_load_pkg::OP_NONE
    |=> illegal_instruction && instr_ready && !mem_request)
    else $error("Unknown word was not refused.");

  // Storage may stall the accept for many cycles, so the address has to hold meanwhile.
  AST_REQUEST_HOLD: assert property (
    mem_request && !mem_accept |=> mem_request && $stable(mem_address))
    else $error("Request dropped before acceptance.");

  AST_QUIET_WITHOUT_RESPONSE: assert property (
    !respond |=> !target_write_enable && !base_write_enable && !load_fault)
    else $error("Register written without a response.");

  COV_BYTE_REVERSE: cover property (
    respond && !fault && op == halfword_load_pkg::OP_BYTE_REVERSE ##1 target_write_enable);
  COV_UPDATE: cover property (base_write_enable);
  COV_FAULT: cover property (load_fault);
  COV_ILLEGAL: cover property (illegal_instruction);
  COV_INDEXED_UPDATE: cover property (respond && op == halfword_load_pkg::OP_ZERO_INDEXED_UPDATE);
endmodule : halfword_load_decode_execute

/* tb/load_partner_model.sv */
// Behavioural register file and data storage facing the halfword load block.
`timescale 1ns/1ps
module load_partner_model (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic [4:0] base_read_index,
  output logic [31:0] base_read_data,
  input wire logic [4:0] index_read_index,
  output logic [31:0] index_read_data,
  input wire logic mem_request,
  input wire logic [31:0] mem_address,
  output logic mem_accept,
  output logic mem_response_valid,
  output logic [15:0] mem_read_data,
  output logic mem_alignment_fault,
  output logic mem_storage_fault,
  input wire logic target_write_enable,
  input wire logic [4:0] target_write_index,
  input wire logic [31:0] target_write_data,
  input wire logic base_write_enable,
  input wire logic [4:0] base_write_index,
  input wire logic [31:0] base_write_data,
  input wire logic [3:0] accept_delay,
  input wire logic [3:0] response_delay,
  input wire logic [1:0] fault_select
);
  logic [31:0] reg_file [32];
  logic [31:0] held_address;

  assign base_read_data = reg_file[base_read_index];
  assign index_read_data = reg_file[index_read_index];

  initial begin
    for (int i = 0; i < 32; i++) begin
      reg_file[i] = 32'h0100_0003 * i + 32'h0000_4000;
    end
    mem_accept = 1'b0;
    mem_response_valid = 1'b0;
    mem_read_data = 16'h0000;
    mem_alignment_fault = 1'b0;
    mem_storage_fault = 1'b0;
  end

  always @(posedge sys_clk) begin
    if (target_write_enable) begin
      reg_file[target_write_index] <= target_write_data;
    end
    if (base_write_enable) begin
      reg_file[base_write_index] <= base_write_data;
    end
  end

  // After each response cycle the data and fault lines show inverted values, so a
  // design that samples them at the wrong time sees garbage rather than a lucky match.
  always begin
    @(negedge sys_clk);
    if (reset_n && mem_request) begin
      repeat (accept_delay) @(negedge sys_clk);
      mem_accept = 1'b1;
      @(posedge sys_clk);
      held_address = mem_address;
      @(negedge sys_clk);
      mem_accept = 1'b0;
      repeat (response_delay) @(negedge sys_clk);
      mem_response_valid = 1'b1;
      mem_read_data = held_address[15:0] ^ 16'h5a3c;
      mem_alignment_fault = fault_select[1];
      mem_storage_fault = fault_select[0];
      @(negedge sys_clk);
      mem_response_valid = 1'b0;
      mem_read_data = ~mem_read_data;
      mem_alignment_fault = ~fault_select[1];
      mem_storage_fault = ~fault_select[0];
    end
  end
endmodule : load_partner_model

/* tb/halfword_load_decode_execute_bench.sv */
// Self-checking bench for the halfword load decode and execute block.
`timescale 1ns/1ps
module halfword_load_decode_execute_bench;
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  logic instr_valid = 1'b0;
  logic [31:0] instr_word = 32'h0000_0000;
  logic instr_ready, mem_request, mem_accept, mem_response_valid;
  logic mem_alignment_fault, mem_storage_fault, illegal_instruction, load_fault;
  logic target_write_enable, base_write_enable;
  logic [4:0] base_read_index, index_read_index, target_write_index, base_write_index;
  logic [31:0] base_read_data, index_read_data, mem_address, target_write_data, base_write_data;
  logic [15:0] mem_read_data;
  logic [3:0] accept_delay = 4'h0;
  logic [3:0] response_delay = 4'h0;
  logic [1:0] fault_select = 2'h0;
  int errors = 0;
  int cmp_count = 0;

  always #5 sys_clk = ~sys_clk;

  halfword_load_decode_execute DUT (.sys_clk, .reset_n, .instr_valid, .instr_word,
    .instr_ready, .base_read_index, .base_read_data, .index_read_index, .index_read_data,
    .mem_request, .mem_address, .mem_accept, .mem_response_valid, .mem_read_data,
    .mem_alignment_fault, .mem_storage_fault, .target_write_enable, .target_write_index,
    .target_write_data, .base_write_enable, .base_write_index, .base_write_data,
    .illegal_instruction, .load_fault);

  load_partner_model u_partner (.sys_clk, .reset_n, .base_read_index, .base_read_data,
    .index_read_index, .index_read_data, .mem_request, .mem_address, .mem_accept,
    .mem_response_valid, .mem_read_data, .mem_alignment_fault, .mem_storage_fault,
    .target_write_enable, .target_write_index, .target_write_data, .base_write_enable,
    .base_write_index, .base_write_data, .accept_delay, .response_delay, .fault_select);

  task automatic chk_bit(input logic got, input logic exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("BAD %0t %s", $time, what);
    end
  endtask : chk_bit

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("BAD %0t %s got %h want %h", $time, what, got, exp);
    end
  endtask : chk_word

  task automatic complete_run();
    $display("errors %0d compares %0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : complete_run

  function automatic logic [31:0] gp(input logic [4:0] i);
    return u_partner.reg_file[i];
  endfunction : gp

  function automatic logic [31:0] xw(input logic [9:0] e, input logic [14:0] f, input logic b);
    return {6'h1f, f, e, b};
  endfunction : xw

  function automatic logic [31:0] zx(input logic [31:0] a);
    return {16'h0, a[15:0] ^ 16'h5a3c};
  endfunction : zx

  function automatic logic [31:0] rev(input logic [31:0] a);
    return {16'h0, a[7:0] ^ 8'h3c, a[15:8] ^ 8'h5a};
  endfunction : rev

  // Issues one word and collects every pulse up to retirement, then judges it.
  task automatic run_load(input logic [31:0] w, input logic [31:0] ad, input logic [31:0] dat,
                          input logic bw, input logic flt, input logic ill);
    logic s_req, s_tw, s_bw, s_flt, s_ill;
    logic [31:0] a, td, bd;
    logic [4:0] ti, bi;
    int n;
    {s_req, s_tw, s_bw, s_flt, s_ill} = 5'h00;
    n = 0;
    while (instr_ready !== 1'b1 && n < 20) begin
      @(negedge sys_clk);
      n++;
    end
    instr_valid = 1'b1;
    instr_word = w;
    @(negedge sys_clk);
    instr_valid = 1'b0;
    instr_word = ~w;
    n = (n >= 20) ? 40 : 0;
    while (!(s_tw || s_flt || s_ill) && n < 40) begin
      if (mem_request === 1'b1 && !s_req) begin
        s_req = 1'b1;
        a = mem_address;
      end
      if (target_write_enable === 1'b1) begin
        {s_tw, ti, td} = {1'b1, target_write_index, target_write_data};
      end
      if (base_write_enable === 1'b1) begin
        {s_bw, bi, bd} = {1'b1, base_write_index, base_write_data};
      end
      s_flt = s_flt | (load_fault === 1'b1);
      s_ill = s_ill | (illegal_instruction === 1'b1);
      @(negedge sys_clk);
      n++;
    end
    if (n >= 40) begin
      errors++;
      $display("BAD %0t load never retired", $time);
      complete_run();
    end
    chk_bit(s_ill, ill, "illegal pulse");
    chk_bit(s_req, !ill, "storage request");
    if (!ill) chk_word(a, ad, "address");
    chk_bit(s_flt, flt, "fault pulse");
    chk_bit(s_tw, !flt && !ill, "target write");
    if (s_tw) chk_word({27'h0, ti}, {27'h0, w[25:21]}, "target index");
    if (s_tw) chk_word(td, dat, "target data");
    chk_bit(s_bw, bw, "base write");
    if (s_bw) chk_word({27'h0, bi}, {27'h0, w[20:16]}, "base index");
    if (s_bw) chk_word(bd, ad, "base write value");
    @(negedge sys_clk);
    chk_bit(instr_ready, 1'b1, "ready after retire");
  endtask : run_load

  task automatic s_indexed();
    logic [31:0] a;
    a = gp(5'h04) + gp(5'h05);
    run_load(xw(10'h316, 15'h1885, 1'b0), a, rev(a), 0, 0, 0);
    a = gp(5'h05);
    run_load(xw(10'h316, 15'h1c05, 1'b1), a, rev(a), 0, 0, 0);
    a = gp(5'h03) + gp(5'h09);
    run_load(xw(10'h117, 15'h2469, 1'b1), a, zx(a), 0, 0, 0);
    a = gp(5'h09);
    run_load(xw(10'h117, 15'h2409, 1'b0), a, zx(a), 0, 0, 0);
  endtask : s_indexed

  task automatic s_disp();
    logic [31:0] a;
    a = gp(5'h02) + 32'hffff_fff0;
    run_load({6'h28, 10'h022, 16'hfff0}, a, zx(a), 0, 0, 0);
    a = 32'hffff_8004;
    run_load({6'h28, 10'h020, 16'h8004}, a, zx(a), 0, 0, 0);
    a = gp(5'h0a) + 32'h0000_0010;
    run_load({6'h29, 10'h10a, 16'h0010}, a, zx(a), 1, 0, 0);
    a = gp(5'h0b) + 32'h0000_0020;
    run_load({6'h29, 10'h16b, 16'h0020}, a, zx(a), 0, 0, 0);
    a = 32'h0000_0030;
    run_load({6'h29, 10'h180, 16'h0030}, a, zx(a), 0, 0, 0);
  endtask : s_disp

  task automatic s_slow_update();
    logic [31:0] a;
    accept_delay = 4'h3;
    response_delay = 4'h5;
    a = gp(5'h0d) + gp(5'h0e);
    run_load(xw(10'h14b, 15'h31ae, 1'b0), a, zx(a), 1, 0, 0);
    a = gp(5'h0e);
    run_load(xw(10'h14b, 15'h300e, 1'b0), a, zx(a), 0, 0, 0);
    accept_delay = 4'h0;
    response_delay = 4'h0;
  endtask : s_slow_update

  task automatic s_faults();
    for (int k = 1; k < 3; k++) begin
      fault_select = k[1:0];
      run_load({6'h29, 10'h1f0, 16'h0002}, gp(5'h10) + 32'h2, 32'h0, 0, 1, 0);
      run_load(xw(10'h14b, 15'h3e31, 1'b0), gp(5'h11) + gp(5'h11), 32'h0, 0, 1, 0);
    end
    fault_select = 2'h0;
  endtask : s_faults

  task automatic s_illegal();
    run_load(xw(10'h177, 15'h18a4, 1'b0), 32'h0, 32'h0, 0, 0, 1);
    run_load({6'h2b, 10'h0c4, 16'h0004}, 32'h0, 32'h0, 0, 0, 1);
  endtask : s_illegal

  initial begin
    repeat (16) @(negedge sys_clk);
    reset_n = 1'b1;
    @(negedge sys_clk);
    chk_bit(instr_ready, 1'b1, "ready after reset");
    chk_bit(mem_request, 1'b0, "no request after reset");
    s_indexed();
    s_disp();
    s_slow_update();
    s_faults();
    s_illegal();
    complete_run();
  end
endmodule : halfword_load_decode_execute_bench
